// [design/bsp_pkg.sv]
// Functional notes
// - Capture write data on both clock rises
// - Low write select on K rise starts write
// - High write select ignores write data inputs
// - Byte selects sampled on both rises during writes
// - Nine-bit lanes, select n governs lane n
// - Byte select shares the edge of its beat
// - Deselected byte leaves memory byte unchanged
// - Unselected bytes never disturb neighbouring lanes
// - One shared address bus sampled on K rise
// - Address width 20 narrow, 19 wide
// - Address ignored when its port is deselected
// - Low read select on K rise starts read
// - Each read returns four consecutive beats
// - Read beats launched on both clock rises
// - Pending burst finishes, then outputs float
// - Outputs float while no read is selected
// - Valid flag marks data, aligned with echo clock
// - Accesses start on rising edge of K
// - Free-running echo clock pair follows K
package bsp_pkg;

	// ****************************************
	// Widths of both configurations
	// ****************************************
	localparam int LANE_W = 9;
	localparam int DATA_W_NARROW = 18;
	localparam int DATA_W_WIDE = 36;
	localparam int ADDR_W_NARROW = 20;
	localparam int ADDR_W_WIDE = 19;
	localparam int BURST_LEN = 4;

	// ****************************************
	// Burst progress codes and reset values
	// ****************************************
	localparam logic [1:0] ST_IDLE = 2'h0;
	localparam logic [1:0] ST_FIRST = 2'h1;
	localparam logic [1:0] ST_SECOND = 2'h2;
	localparam logic [2:0] WB_IDLE = 3'h0;
	localparam logic [2:0] WB_BEAT0 = 3'h1;
	localparam logic [2:0] WB_BEAT1 = 3'h2;
	localparam logic [2:0] WB_BEAT2 = 3'h3;
	localparam logic [2:0] WB_BEAT3 = 3'h4;
	localparam logic [1:0] CAP_LAST = 2'h3;

	// ****************************************
	// Link clock divider phases
	// ****************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int LINK_DIV = 4;
	localparam logic [1:0] PH_RST = 2'h0;
	localparam logic [1:0] PH_MID_HIGH = 2'h0;
	localparam logic [1:0] PH_MID_LOW = 2'h2;
	localparam logic SLOT_READ = 1'b0;

endpackage : bsp_pkg

// [design/bsp_if.sv]
interface bsp_if #(
	parameter int DATA_W = bsp_pkg::DATA_W_NARROW,
	parameter int ADDR_W = bsp_pkg::ADDR_W_NARROW,
	parameter int LANES = DATA_W / bsp_pkg::LANE_W
);
	logic in_clk;
	logic in_clk_n;
	logic write_port_select_n;
	logic read_port_select_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [LANES-1:0] byte_lane_write_select_n;
	logic [DATA_W-1:0] rdata;
	logic rdata_oe;
	logic output_valid_flag;
	logic echo_clock_out;
	logic echo_clock_out_n;

	// ****************************************
	// Memory end and controller end
	// ****************************************
	modport mem (
		input in_clk, in_clk_n, write_port_select_n, read_port_select_n,
		input addr, wdata, byte_lane_write_select_n,
		output rdata, rdata_oe, output_valid_flag, echo_clock_out, echo_clock_out_n
	);
	modport ctrl (
		output in_clk, in_clk_n, write_port_select_n, read_port_select_n,
		output addr, wdata, byte_lane_write_select_n,
		input rdata, rdata_oe, output_valid_flag, echo_clock_out, echo_clock_out_n
	);

endinterface : bsp_if

// [design/bsp_sram_ctl.sv]
module bsp_sram_ctl #(
	parameter int DATA_W = bsp_pkg::DATA_W_NARROW,
	parameter int ADDR_W = bsp_pkg::ADDR_W_NARROW,
	parameter int LANES = DATA_W / bsp_pkg::LANE_W
) (
	bsp_if.ctrl link,
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rd_req_i,
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic rd_ready_o,
	output logic [4*DATA_W-1:0] rd_data_o,
	output logic rd_valid_o,
	input wire logic wr_req_i,
	input wire logic [ADDR_W-1:0] wr_addr_i,
	input wire logic [4*DATA_W-1:0] wr_data_i,
	input wire logic [4*LANES-1:0] wr_bws_n_i,
	output logic wr_ready_o
);
	// ****************************************
	// Link clock divider
	// ****************************************
	logic [1:0] ph_reg;
	logic [1:0] ph_next;
	logic rst_d_reg;
	logic k_reg;
	logic e_hi;
	logic e_lo;

	assign ph_next = ph_reg + 2'h1;
	assign e_hi = (ph_reg == bsp_pkg::PH_MID_HIGH);
	assign e_lo = (ph_reg == bsp_pkg::PH_MID_LOW);

	// Counts on through reset so the memory end sees clock edges
	always_ff @(posedge clk_i) begin
		rst_d_reg <= rst_i;
		ph_reg <= (rst_i && !rst_d_reg) ? bsp_pkg::PH_RST : ph_next;
		k_reg <= !ph_next[1];
	end

	assign link.in_clk = k_reg;
	assign link.in_clk_n = !k_reg;

	// ****************************************
	// Request holding and slot alternation
	// ****************************************
	logic slot_reg;
	logic rd_pend_reg;
	logic wr_pend_reg;
	logic [ADDR_W-1:0] rd_hold_reg;
	logic [ADDR_W-1:0] wr_hold_reg;
	logic [4*DATA_W-1:0] wd_hold_reg;
	logic [4*LANES-1:0] wm_hold_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic rps_n_reg;
	logic wps_n_reg;
	logic wr_start;

	assign rd_ready_o = !rd_pend_reg;
	assign wr_ready_o = !wr_pend_reg;
	assign wr_start = e_lo && (slot_reg != bsp_pkg::SLOT_READ) && wr_pend_reg;

	// One request of each kind waits for its own slot
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_pend_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
		end else begin
			if (rd_req_i && !rd_pend_reg)
				rd_pend_reg <= 1'b1;
			else if (e_lo && slot_reg == bsp_pkg::SLOT_READ)
				rd_pend_reg <= 1'b0;
			if (wr_req_i && !wr_pend_reg)
				wr_pend_reg <= 1'b1;
			else if (wr_start)
				wr_pend_reg <= 1'b0;
		end
		if (rd_req_i && !rd_pend_reg)
			rd_hold_reg <= rd_addr_i;
		// Data and lane mask are taken with the request, not at the slot
		if (wr_req_i && !wr_pend_reg) begin
			wr_hold_reg <= wr_addr_i;
			wd_hold_reg <= wr_data_i;
			wm_hold_reg <= wr_bws_n_i;
		end
	end

	// Selects set mid-low, held across the K rise, cleared mid-high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot_reg <= bsp_pkg::SLOT_READ;
			rps_n_reg <= 1'b1;
			wps_n_reg <= 1'b1;
			addr_reg <= '0;
		end else if (e_lo) begin
			slot_reg <= !slot_reg;
			rps_n_reg <= !(slot_reg == bsp_pkg::SLOT_READ && rd_pend_reg);
			wps_n_reg <= !wr_start;
			if (slot_reg == bsp_pkg::SLOT_READ && rd_pend_reg)
				addr_reg <= rd_hold_reg;
			else if (wr_start)
				addr_reg <= wr_hold_reg;
		end else if (e_hi) begin
			rps_n_reg <= 1'b1;
			wps_n_reg <= 1'b1;
		end
	end

	assign link.read_port_select_n = rps_n_reg;
	assign link.write_port_select_n = wps_n_reg;
	assign link.addr = addr_reg;

	// ****************************************
	// Write beats
	// ****************************************
	logic [2:0] wcnt_reg;
	logic [4*DATA_W-1:0] wbuf_reg;
	logic [4*LANES-1:0] wbws_reg;
	logic [DATA_W-1:0] d_reg;
	logic [LANES-1:0] bws_reg;

	// Beats centred between the edges that sample them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wcnt_reg <= bsp_pkg::WB_IDLE;
			d_reg <= '0;
			bws_reg <= '1;
		end else if (e_hi) begin
			if (wcnt_reg == bsp_pkg::WB_BEAT0 || wcnt_reg == bsp_pkg::WB_BEAT2) begin
				d_reg <= wbuf_reg[(wcnt_reg == bsp_pkg::WB_BEAT0 ? 0 : 2)*DATA_W +: DATA_W];
				bws_reg <= wbws_reg[(wcnt_reg == bsp_pkg::WB_BEAT0 ? 0 : 2)*LANES +: LANES];
				wcnt_reg <= wcnt_reg + 3'h1;
			end else begin
				d_reg <= '0;
				bws_reg <= '1;
			end
		end else if (e_lo) begin
			if (wcnt_reg == bsp_pkg::WB_BEAT1 || wcnt_reg == bsp_pkg::WB_BEAT3) begin
				d_reg <= wbuf_reg[(wcnt_reg == bsp_pkg::WB_BEAT1 ? 1 : 3)*DATA_W +: DATA_W];
				bws_reg <= wbws_reg[(wcnt_reg == bsp_pkg::WB_BEAT1 ? 1 : 3)*LANES +: LANES];
			end else begin
				d_reg <= '0;
				bws_reg <= '1;
			end
			if (wr_start)
				wcnt_reg <= bsp_pkg::WB_BEAT0;
			else if (wcnt_reg == bsp_pkg::WB_BEAT3)
				wcnt_reg <= bsp_pkg::WB_IDLE;
			else if (wcnt_reg == bsp_pkg::WB_BEAT1)
				wcnt_reg <= bsp_pkg::WB_BEAT2;
		end
		// Copied at the slot, so a new request cannot disturb a running burst
		if (wr_start) begin
			wbuf_reg <= wd_hold_reg;
			wbws_reg <= wm_hold_reg;
		end
	end

	assign link.wdata = d_reg;
	assign link.byte_lane_write_select_n = bws_reg;

	// ****************************************
	// Read capture
	// ****************************************
	logic [1:0] rcap_reg;
	logic [3*DATA_W-1:0] rbuf_reg;

	// Sampled mid-phase, away from the launching edges of our own clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rcap_reg <= 2'h0;
			rd_valid_o <= 1'b0;
			rd_data_o <= '0;
		end else begin
			rd_valid_o <= 1'b0;
			if ((e_hi || e_lo) && link.output_valid_flag && link.rdata_oe) begin
				rcap_reg <= rcap_reg + 2'h1;
				if (rcap_reg == bsp_pkg::CAP_LAST) begin
					rd_data_o <= {link.rdata, rbuf_reg};
					rd_valid_o <= 1'b1;
				end else begin
					rbuf_reg[rcap_reg*DATA_W +: DATA_W] <= link.rdata;
				end
			end
		end
	end

endmodule : bsp_sram_ctl

// [design/bsp_sram_dev.sv]
module bsp_sram_dev #(
	parameter int DATA_W = bsp_pkg::DATA_W_NARROW,
	parameter int ADDR_W = bsp_pkg::ADDR_W_NARROW,
	parameter int MEM_AW = ADDR_W
) (
	bsp_if.mem link,
	input wire logic rst_i
);
	localparam int LW = bsp_pkg::LANE_W;
	localparam int LANES = DATA_W / LW;
	localparam int WORDS = (2 ** MEM_AW) * bsp_pkg::BURST_LEN;

	// ****************************************
	// Reset into the link clock domain
	// ****************************************
	logic rst_s1_reg;
	logic rst_s2_reg;
	logic rst_s3_reg;
	logic rst_k_reg;

	// Stage one feeds stage two only
	always_ff @(posedge link.in_clk) begin
		rst_s1_reg <= rst_i;
		rst_s2_reg <= rst_s1_reg;
		rst_s3_reg <= rst_s2_reg;
	end

	// A change counts once the last two stages agree
	always_ff @(posedge link.in_clk) begin
		if (rst_s2_reg == rst_s3_reg)
			rst_k_reg <= rst_s3_reg;
	end

	// ****************************************
	// Storage
	// ****************************************
	// Four words per address, one per burst beat
	logic [DATA_W-1:0] mem_q [0:WORDS-1];

	// ****************************************
	// Port select decode at the K rise
	// ****************************************
	logic [1:0] rd_st_reg;
	logic [1:0] wr_st_reg;
	logic [ADDR_W-1:0] rd_addr_reg;
	logic [ADDR_W-1:0] wr_addr_reg;
	logic rd_take;
	logic wr_take;

	// A port can take a new burst on the edge its last one ends
	assign rd_take = !link.read_port_select_n
		&& (rd_st_reg != bsp_pkg::ST_FIRST);
	// Read wins if both were ever shown together
	assign wr_take = !link.write_port_select_n
		&& !rd_take
		&& (wr_st_reg != bsp_pkg::ST_FIRST);

	// Read burst progress, started only by a K rise
	always_ff @(posedge link.in_clk) begin
		if (rst_k_reg) begin
			rd_st_reg <= bsp_pkg::ST_IDLE;
		end else if (rd_take) begin
			rd_st_reg <= bsp_pkg::ST_FIRST;
		end else if (rd_st_reg == bsp_pkg::ST_FIRST) begin
			rd_st_reg <= bsp_pkg::ST_SECOND;
		end else begin
			rd_st_reg <= bsp_pkg::ST_IDLE;
		end
	end

	// Write burst progress; a high select leaves the port idle
	always_ff @(posedge link.in_clk) begin
		if (rst_k_reg) begin
			wr_st_reg <= bsp_pkg::ST_IDLE;
		end else if (wr_take) begin
			wr_st_reg <= bsp_pkg::ST_FIRST;
		end else if (wr_st_reg == bsp_pkg::ST_FIRST) begin
			wr_st_reg <= bsp_pkg::ST_SECOND;
		end else begin
			wr_st_reg <= bsp_pkg::ST_IDLE;
		end
	end

	// Shared address bus, latched only for a selected port
	always_ff @(posedge link.in_clk) begin
		if (rst_k_reg) begin
			rd_addr_reg <= '0;
			wr_addr_reg <= '0;
		end else begin
			if (rd_take)
				rd_addr_reg <= link.addr;
			if (wr_take)
				wr_addr_reg <= link.addr;
		end
	end

	// ****************************************
	// Write beats from the K# rise
	// ****************************************
	logic [DATA_W-1:0] wneg_d_reg;
	logic [LANES-1:0] wneg_bws_reg;

	// Held half a cycle so all array writes sit in one process
	always_ff @(posedge link.in_clk_n) begin
		if (rst_k_reg) begin
			wneg_d_reg <= '0;
			wneg_bws_reg <= '1;
		end else if (wr_st_reg != bsp_pkg::ST_IDLE) begin
			wneg_d_reg <= link.wdata;
			wneg_bws_reg <= link.byte_lane_write_select_n;
		end else begin
			wneg_bws_reg <= '1;
		end
	end

	// ****************************************
	// Array update at the K rise
	// ****************************************
	logic [1:0] wr_lo_beat;
	logic [1:0] wr_hi_beat;
	logic [MEM_AW+1:0] wr_lo_idx;
	logic [MEM_AW+1:0] wr_hi_idx;
	logic wr_beats_now;

	assign wr_beats_now = (wr_st_reg != bsp_pkg::ST_IDLE);
	assign wr_lo_beat = (wr_st_reg == bsp_pkg::ST_FIRST) ? 2'h0 : 2'h2;
	assign wr_hi_beat = wr_lo_beat + 2'h1;
	assign wr_lo_idx = {wr_addr_reg[MEM_AW-1:0], wr_lo_beat};
	assign wr_hi_idx = {wr_addr_reg[MEM_AW-1:0], wr_hi_beat};

	// Two beats per K rise: the held K# beat and the one on the pins
	always_ff @(posedge link.in_clk) begin
		if (!rst_k_reg && wr_beats_now) begin
			for (int i = 0; i < LANES; i++) begin
				if (!wneg_bws_reg[i])
					mem_q[wr_lo_idx][i*LW +: LW] <= wneg_d_reg[i*LW +: LW];
				if (!link.byte_lane_write_select_n[i])
					mem_q[wr_hi_idx][i*LW +: LW] <= link.wdata[i*LW +: LW];
			end
		end
	end

	// ****************************************
	// Read launch on both rises
	// ****************************************
	logic [DATA_W-1:0] q_pos_reg;
	logic [DATA_W-1:0] q_neg_reg;
	logic vld_pos_reg;
	logic vld_neg_reg;
	logic [MEM_AW+1:0] rd_pos_idx;
	logic [MEM_AW+1:0] rd_neg_idx;

	// Beats 1 and 3 at K, beats 0 and 2 at K#
	assign rd_pos_idx = {rd_addr_reg[MEM_AW-1:0],
		(rd_st_reg == bsp_pkg::ST_FIRST) ? 2'h1 : 2'h3};
	assign rd_neg_idx = {rd_addr_reg[MEM_AW-1:0],
		(rd_st_reg == bsp_pkg::ST_FIRST) ? 2'h0 : 2'h2};

	// K-rise half of each beat pair
	always_ff @(posedge link.in_clk) begin
		if (rst_k_reg) begin
			q_pos_reg <= '0;
			vld_pos_reg <= 1'b0;
		end else if (rd_st_reg != bsp_pkg::ST_IDLE) begin
			q_pos_reg <= mem_q[rd_pos_idx];
			vld_pos_reg <= 1'b1;
		end else begin
			vld_pos_reg <= 1'b0;
		end
	end

	// K#-rise half; first beat leaves half a cycle after the select
	always_ff @(posedge link.in_clk_n) begin
		if (rst_k_reg) begin
			q_neg_reg <= '0;
			vld_neg_reg <= 1'b0;
		end else if (rd_st_reg != bsp_pkg::ST_IDLE) begin
			q_neg_reg <= mem_q[rd_neg_idx];
			vld_neg_reg <= 1'b1;
		end else begin
			vld_neg_reg <= 1'b0;
		end
	end

	// ****************************************
	// Output pins and echo clocks
	// ****************************************
	// Clock level picks the half that was launched last
	assign link.rdata = link.in_clk ? q_pos_reg : q_neg_reg;
	// Valid changes only on clock edges, so it lines up with the echo
	assign link.output_valid_flag = link.in_clk ? vld_pos_reg : vld_neg_reg;
	// Drivers float whenever no beat is on the pins
	assign link.rdata_oe = link.output_valid_flag;
	// Echo runs free, even in reset
	assign link.echo_clock_out = link.in_clk;
	assign link.echo_clock_out_n = link.in_clk_n;

endmodule : bsp_sram_dev

// [tb/bsp_asserts.sv]
module bsp_asserts #(
	parameter int LANES = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_clk,
	input wire logic in_clk_n,
	input wire logic write_port_select_n,
	input wire logic read_port_select_n,
	input wire logic [LANES-1:0] byte_lane_write_select_n,
	input wire logic rdata_oe,
	input wire logic output_valid_flag,
	input wire logic echo_clock_out,
	input wire logic echo_clock_out_n
);
	// ****************************************
	// Link checks, sampled on K rise, except the echo and valid-timing checks, which sample on clk_i
	// ****************************************
	// Echo pair complementary, following K, toggling every two clocks
	property p_echo;
		@(posedge clk_i) disable iff (rst_i)
		echo_clock_out == in_clk && echo_clock_out_n == !echo_clock_out
		&& echo_clock_out != $past(echo_clock_out, 2);
	endproperty
	a_echo: assert property (p_echo) else $error("echo clock off");
	// Valid moves only together with an echo clock edge
	property p_oe;
		@(posedge clk_i) disable iff (rst_i) rdata_oe == output_valid_flag
		&& (!$changed(output_valid_flag) || $changed(echo_clock_out));
	endproperty
	a_oe: assert property (p_oe) else $error("drive enable and valid differ");
	property p_read;
		@(posedge in_clk) disable iff (rst_i)
		!read_port_select_n && !output_valid_flag |=> output_valid_flag [*2];
	endproperty
	a_read: assert property (p_read) else $error("read burst missing");
	property p_cause;
		@(posedge in_clk) disable iff (rst_i)
		$rose(output_valid_flag) |-> !$past(read_port_select_n);
	endproperty
	a_cause: assert property (p_cause) else $error("valid without read");
	// Burst is four beats long unless the next read follows
	property p_end;
		@(posedge in_clk) disable iff (rst_i) $rose(output_valid_flag) |=>
		output_valid_flag ##1 (!output_valid_flag || !$past(read_port_select_n));
	endproperty
	a_end: assert property (p_end) else $error("burst length wrong");
	property p_idle;
		@(posedge in_clk) disable iff (rst_i)
		!output_valid_flag && read_port_select_n |=> !output_valid_flag;
	endproperty
	a_idle: assert property (p_idle) else $error("outputs driven when idle");
	property p_wsel;
		@(posedge in_clk) disable iff (rst_i) !write_port_select_n |=> write_port_select_n;
	endproperty
	a_wsel: assert property (p_wsel) else $error("write select held too long");
	property p_slot;
		@(posedge in_clk) disable iff (rst_i) !(!write_port_select_n && !read_port_select_n);
	endproperty
	a_slot: assert property (p_slot) else $error("both selects in one slot");
	property p_lanes;
		@(posedge in_clk) disable iff (rst_i) write_port_select_n
		&& $past(write_port_select_n) && $past(write_port_select_n, 2)
		|-> &byte_lane_write_select_n;
	endproperty
	a_lanes: assert property (p_lanes) else $error("lane select outside burst");
endmodule : bsp_asserts

// [tb/burst_sram_split_port_io_tb_top.sv]
module burst_sram_split_port_io_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b0;
	logic checks_off = 1'b1;
	logic rd_req_i = 1'b0;
	logic [19:0] rd_addr_i = 20'h0;
	logic rd_ready_o;
	logic [71:0] rd_data_o;
	logic rd_valid_o;
	logic wr_req_i = 1'b0;
	logic [19:0] wr_addr_i = 20'h0;
	logic [71:0] wr_data_i = 72'h0;
	logic [7:0] wr_bws_n_i = 8'hFF;
	logic wr_ready_o;
	int n_fail = 0;
	int checked = 0;
	logic [71:0] mem_model [64];
	bsp_if link ();
	bsp_sram_ctl i_bsp_sram_ctl (.link(link), .clk_i(clk_i),
		.rst_i(rst_i), .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ready_o(rd_ready_o),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .wr_req_i(wr_req_i),
		.wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_bws_n_i(wr_bws_n_i),
		.wr_ready_o(wr_ready_o));
	// Small array keeps the run short; upper address bits are ignored
	bsp_sram_dev #(.MEM_AW(6)) i_bsp_sram_dev (.link(link),
		.rst_i(rst_i));
	// Checks stay off until reset first rises and the divider is known
	bsp_asserts #(.LANES(2)) i_bsp_asserts (.clk_i(clk_i), .rst_i(rst_i || checks_off),
		.in_clk(link.in_clk), .in_clk_n(link.in_clk_n),
		.write_port_select_n(link.write_port_select_n),
		.read_port_select_n(link.read_port_select_n),
		.byte_lane_write_select_n(link.byte_lane_write_select_n), .rdata_oe(link.rdata_oe),
		.output_valid_flag(link.output_valid_flag), .echo_clock_out(link.echo_clock_out),
		.echo_clock_out_n(link.echo_clock_out_n));
	// ****************************************
	// Clock and helpers
	// ****************************************
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task tally_and_finish;
		if (n_fail == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task check(input logic [71:0] seen, input logic [71:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task timeout;
		n_fail++;
		$display("[FAIL] %0t wait ran out", $time);
		tally_and_finish();
	endtask : timeout
	task wait_ready(input bit w);
		for (int i = 0; i < 40; i++) begin
			@(negedge clk_i);
			if ((w ? wr_ready_o : rd_ready_o) === 1'b1) return;
		end
		timeout();
	endtask : wait_ready
	// Lane i of the 8 spans bits 9i+8:9i across the four beats
	task wr(input logic [19:0] a, input logic [71:0] d, input logic [7:0] m);
		wait_ready(1'b1);
		wr_req_i = 1'b1;
		wr_addr_i = a;
		wr_data_i = d;
		wr_bws_n_i = m;
		@(negedge clk_i);
		wr_req_i = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (!m[i]) mem_model[a][i*9 +: 9] = d[i*9 +: 9];
		end
	endtask : wr
	task rd(input logic [19:0] a);
		wait_ready(1'b0);
		rd_req_i = 1'b1;
		rd_addr_i = a;
		@(negedge clk_i);
		rd_req_i = 1'b0;
	endtask : rd
	task rd_get(input logic [19:0] a);
		for (int i = 0; i < 60; i++) begin
			@(negedge clk_i);
			if (rd_valid_o === 1'b1) begin
				check(rd_data_o, mem_model[a]);
				return;
			end
		end
		timeout();
	endtask : rd_get
	// Posted writes land within two K cycles plus a slot wait
	task settle;
		repeat (16) @(negedge clk_i);
	endtask : settle
	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		check({70'h0, rd_ready_o, wr_ready_o}, 72'h3);
		check({71'h0, link.rdata_oe}, 72'h0);
	endtask : t_reset
	// Back-to-back writes, then back-to-back reads
	task t_full;
		wr(20'h1, 72'h123456789ABCDEF012, 8'h00);
		wr(20'h2, 72'hFEDCBA9876543210AB, 8'h00);
		settle();
		rd(20'h1);
		rd(20'h2);
		rd_get(20'h1);
		rd_get(20'h2);
		repeat (4) @(negedge clk_i);
		check({71'h0, link.output_valid_flag}, 72'h0);
	endtask : t_full
	// Lane masks per beat, each merge checked, neighbour word untouched
	task t_partial;
		logic [7:0] masks [6];
		masks = '{8'h55, 8'hAA, 8'hF0, 8'h0F, 8'h7E, 8'hFF};
		foreach (masks[i]) begin
			wr(20'h1, {9{masks[i]}} ^ 72'h0F1E2D3C4B5A697887, masks[i]);
			settle();
			rd(20'h1);
			rd_get(20'h1);
		end
		rd(20'h2);
		rd_get(20'h2);
	endtask : t_partial
	initial begin
		// Divider zeroes on a rising reset, so reset rises after one clock
		@(negedge clk_i);
		rst_i = 1'b1;
		checks_off = 1'b0;
		repeat (40) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (44) @(negedge clk_i);
		t_reset();
		t_full();
		t_partial();
		tally_and_finish();
	end
endmodule : burst_sram_split_port_io_tb_top
